// ### include/acs_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the
  converter sequencer. Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Register byte addresses
`define ACS_ADDR_CTRL    8'h00
`define ACS_ADDR_TIMING  8'h04
`define ACS_ADDR_RESULT  8'h08
`define ACS_ADDR_STATUS  8'h0c
`define ACS_ADDR_TRIG    8'h10
`define ACS_ADDR_ANCFG   8'h14
`define ACS_ADDR_PORT    8'h18

// Control register fields
`define ACS_CTRL_ON      0
`define ACS_CTRL_GO      1
`define ACS_CTRL_CHS_LO  2
`define ACS_CTRL_CHS_HI  5
// Timing register fields
`define ACS_TIM_CS_LO    0
`define ACS_TIM_CS_HI    2
`define ACS_TIM_ACQ_LO   3
`define ACS_TIM_ACQ_HI   5
// Status register fields
`define ACS_STAT_DONE    0
`define ACS_STAT_BUSY    1
// Widths
`define ACS_RES_W        10
`define ACS_PORT_W       8
`define ACS_MODE_LO      0
`define ACS_MODE_HI      3

// Compare unit mode that arms the special event trigger
`define ACS_TRIG_MODE    4'hb
// Clock select low bits that pick the RC source
`define ACS_CS_RC        2'h3
// Smallest divider, in oscillator periods
`define ACS_DIV_MIN      7'h02
// Acquisition lengths in bit periods, codes 7 down to 0, five bits each
`define ACS_ACQ_TABLE    {5'h14, 5'h10, 5'h0c, 5'h08, 5'h06, 5'h04, 5'h02, 5'h00}
`define ACS_ACQ_FLD_W    5
// Phase lengths
`define ACS_CONV_TADS    5'h0b
`define ACS_WAIT_TADS    5'h02
`define ACS_DISCH_TADS   5'h01
`define ACS_INSTR_CLKS   5'h04
// First trial code of the successive approximation
`define ACS_SAR_MSB      10'h200
// Reset values
`define ACS_ANCFG_RST    8'hff

`endif

// ### include/acs_pkg.sv
/*
  Types of the converter sequencer: states, carriers and state records.
  Assumes acs_defines.svh is on the include path.
*/
`include "acs_defines.svh"

package acs_pkg;

  // Sequencer phases; code 3'b111 is illegal
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_DISCH  = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_ACQ    = 3'b011,
    ST_DLY    = 3'b100,
    ST_CONV   = 3'b101,
    ST_WAIT   = 3'b110
  } acs_state_t;

  // Controls towards the sample-and-hold and comparator array
  typedef struct packed {
    logic                   discharge;
    logic                   sample;
    logic                   convert;
    logic [`ACS_RES_W-1:0]  trial;
    logic [3:0]             channel;
  } acs_ana_t;

  // Bit-period generator state
  typedef struct packed {
    logic [2:0] rc_sync;
    logic       rc_lvl;
    logic [5:0] cnt;
    logic       tick;
  } acs_tick_st_t;

  // Sequencer state
  typedef struct packed {
    acs_state_t              st;
    logic                    on;
    logic                    go;
    logic [3:0]              chs;
    logic [2:0]              cs;
    logic [2:0]              acq;
    logic [3:0]              mode;
    logic [`ACS_PORT_W-1:0]  ancfg;
    logic [`ACS_RES_W-1:0]   result;
    logic                    done;
    logic [4:0]              cnt;
    logic [`ACS_RES_W-1:0]   trial;
    logic                    rdiv;
    logic [`ACS_PORT_W-1:0]  ps1;
    logic [`ACS_PORT_W-1:0]  ps2;
    logic [`ACS_PORT_W-1:0]  ps3;
    logic [`ACS_PORT_W-1:0]  pin_lvl;
    logic                    wreq;
    logic [31:0]             rdata;
    logic                    tclr;
    acs_ana_t                ana;
  } acs_seq_st_t;

endpackage

// ### verilog/acs_tick_gen.sv
/*
  Bit-period tick generator: divides core_clk or follows the RC source.
  Assumes rc_clk_in is asynchronous and much slower than core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module acs_tick_gen
  import acs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic [2:0] conv_clock_select,
  input  wire logic       run,
  input  wire logic       rc_clk_in,
  output logic            tick
);

  acs_tick_st_t s;      // Registered state
  acs_tick_st_t n;      // Next state
  logic [5:0]   last;   // Terminal count of the divider

  // Next-state logic
  always_comb begin
    n = s;
    // Codes 000,100,001,101,010,110 give 2..64 periods
    last = 6'((`ACS_DIV_MIN << {conv_clock_select[1:0], conv_clock_select[2]}) - 7'h01);
    // Three stages; the level moves only when stages two and three agree
    n.rc_sync = {s.rc_sync[1:0], rc_clk_in};
    if (s.rc_sync[1] == s.rc_sync[2]) begin
      n.rc_lvl = s.rc_sync[1];
    end
    if (!run) begin
      // Held: restarts a full period when released
      n.cnt  = 6'h00;
      n.tick = 1'b0;
    end else if (conv_clock_select[1:0] == `ACS_CS_RC) begin
      // RC source: one tick per rising edge, phase cannot be aligned
      n.cnt  = 6'h00;
      n.tick = n.rc_lvl & ~s.rc_lvl;
    end else begin
      n.tick = (s.cnt == last);
      n.cnt  = n.tick ? 6'h00 : s.cnt + 6'h01;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign tick = s.tick;

endmodule

`default_nettype wire

// ### verilog/acs_sequencer.sv
/*
  Conversion sequencer of a 10-bit successive-approximation converter,
  with its register file on Avalon-MM. Assumes cmp_in and special_trig
  are produced on core_clk; port_pins and rc_clk_in are asynchronous.
*/
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
// Function
// - Conversion lasts eleven bit periods
// - Clock select code picks divider or RC
// - Zero acquisition code delays one instruction cycle
// - Analog-configured pins read as zero
// - Code 010 samples four periods, then converts
// - Clearing start aborts a running conversion
// - Abort leaves the result pair unchanged
// - Two-period wait, then acquisition restarts
// - Discharge precedes every sampling phase
// - Trigger starts only in mode 1011, on
// - Each trigger clears the trigger timer
// - Converter off: trigger only clears timer
// - Completion loads result, clears start, flags done
// - Acquisition codes 001 to 111 give 2 to 20 periods
// - Code 000 converts after a four-clock delay
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   cmp_in,
  input  wire logic                   rc_clk_in,
  input  wire logic                   special_trig,
  input  wire logic [`ACS_PORT_W-1:0] port_pins,
  output acs_ana_t                    ana,
  output logic                        timer_clear
);

  acs_seq_st_t             s;        // Registered state
  acs_seq_st_t             n;        // Next state
  logic                    tick;     // One bit period elapsed
  logic [`ACS_PORT_W-1:0]  lvl_nxt;  // Filtered pin levels
  logic [4:0]              acq_len;  // Acquisition periods
  logic [31:0]             rd;       // Read mux
  logic                    wr_take;  // Write takes effect now
  logic                    trig_ok;  // Trigger armed by mode
  logic [3:0]              bidx;     // Bit under trial
  logic [`ACS_RES_W-1:0]   tmp;      // Trial code after this period

  // Bit-period source; the divider restarts whenever the phase changes
  acs_tick_gen u_tick (
    .core_clk          (core_clk),
    .resetn            (resetn),
    .clk_en            (clk_en),
    .conv_clock_select (s.cs),
    .run               (s.on & ~s.rdiv),
    .rc_clk_in         (rc_clk_in),
    .tick              (tick)
  );

  // Pin filter: a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `ACS_PORT_W; gi++) begin : g_pin
      assign lvl_nxt[gi] = (s.ps2[gi] == s.ps3[gi]) ? s.ps2[gi] : s.pin_lvl[gi];
    end
  endgenerate

  // Acquisition length lookup
  assign acq_len = 5'(`ACS_ACQ_TABLE >> (s.acq * `ACS_ACQ_FLD_W));
  assign wr_take = avs_write & ~s.wreq;
  assign trig_ok = special_trig & (s.mode == `ACS_TRIG_MODE);
  assign bidx    = 4'(`ACS_RES_W - s.cnt);

  // Register read mux
  always_comb begin
    rd = '0;
    unique case (avs_address)
      `ACS_ADDR_CTRL: begin
        rd[`ACS_CTRL_ON]                    = s.on;
        rd[`ACS_CTRL_GO]                    = s.go;
        rd[`ACS_CTRL_CHS_HI:`ACS_CTRL_CHS_LO] = s.chs;
      end
      `ACS_ADDR_TIMING: begin
        rd[`ACS_TIM_CS_HI:`ACS_TIM_CS_LO]   = s.cs;
        rd[`ACS_TIM_ACQ_HI:`ACS_TIM_ACQ_LO] = s.acq;
      end
      `ACS_ADDR_RESULT: rd[`ACS_RES_W-1:0]  = s.result;
      `ACS_ADDR_STATUS: begin
        rd[`ACS_STAT_DONE] = s.done;
        rd[`ACS_STAT_BUSY] = (s.st == ST_ACQ) | (s.st == ST_DLY) | (s.st == ST_CONV);
      end
      `ACS_ADDR_TRIG:   rd[`ACS_MODE_HI:`ACS_MODE_LO] = s.mode;
      `ACS_ADDR_ANCFG:  rd[`ACS_PORT_W-1:0] = s.ancfg;
      // Analog pins never show their digital level
      `ACS_ADDR_PORT:   rd[`ACS_PORT_W-1:0] = s.pin_lvl & ~s.ancfg;
      default:          rd = '0;
    endcase
  end

  // Next-state logic: bus, trigger, then the phase sequencer
  always_comb begin
    n        = s;
    tmp      = s.trial;
    n.tclr   = 1'b0;
    n.wreq   = 1'b1;
    n.rdiv   = 1'b0;
    n.ps1    = port_pins;
    n.ps2    = s.ps1;
    n.ps3    = s.ps2;
    n.pin_lvl = lvl_nxt;

    // One wait state per access; read data is staged with it
    if ((avs_read | avs_write) & s.wreq) begin
      n.wreq  = 1'b0;
      n.rdata = rd;
    end

    // Register writes
    if (wr_take) begin
      unique case (avs_address)
        `ACS_ADDR_CTRL: begin
          n.on  = avs_writedata[`ACS_CTRL_ON];
          n.chs = avs_writedata[`ACS_CTRL_CHS_HI:`ACS_CTRL_CHS_LO];
          // Clearing start mid-conversion aborts it next cycle
          n.go  = avs_writedata[`ACS_CTRL_GO] & avs_writedata[`ACS_CTRL_ON];
        end
        `ACS_ADDR_TIMING: begin
          n.cs  = avs_writedata[`ACS_TIM_CS_HI:`ACS_TIM_CS_LO];
          n.acq = avs_writedata[`ACS_TIM_ACQ_HI:`ACS_TIM_ACQ_LO];
        end
        `ACS_ADDR_RESULT: n.result = avs_writedata[`ACS_RES_W-1:0];
        // Write one to clear the done flag
        `ACS_ADDR_STATUS: begin
          if (avs_writedata[`ACS_STAT_DONE]) begin
            n.done = 1'b0;
          end
        end
        `ACS_ADDR_TRIG:   n.mode  = avs_writedata[`ACS_MODE_HI:`ACS_MODE_LO];
        `ACS_ADDR_ANCFG:  n.ancfg = avs_writedata[`ACS_PORT_W-1:0];
        default: ;
      endcase
    end

    // Special event: timer always cleared, start only while on
    if (trig_ok) begin
      n.tclr = 1'b1;
      if (n.on) begin
        n.go = 1'b1;
      end
    end

    // Phase sequencer
    unique case (s.st)
      ST_OFF: begin
        if (s.on) begin
          n.st  = ST_DISCH;
          n.cnt = '0;
        end
      end
      // Array is emptied before each sampling phase
      ST_DISCH: begin
        if (tick) begin
          if (s.cnt == `ACS_DISCH_TADS - 5'h01) begin
            n.st = ST_SAMPLE;
          end else begin
            n.cnt = s.cnt + 5'h01;
          end
        end
      end
      // Tracks the input until software or the trigger starts
      ST_SAMPLE: begin
        if (s.go) begin
          n.cnt = '0;
          // Zero code: no acquisition, only the instruction delay
          n.st  = (s.acq == 3'h0) ? ST_DLY : ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (!s.go) begin
          n.st  = ST_WAIT;
          n.cnt = '0;
        end else if (tick) begin
          if (s.cnt == acq_len - 5'h01) begin
            n.st  = ST_CONV;
            n.cnt = '0;
          end else begin
            n.cnt = s.cnt + 5'h01;
          end
        end
      end
      // Counts core clocks so a sleep entry can happen first
      ST_DLY: begin
        if (!s.go) begin
          n.st  = ST_WAIT;
          n.cnt = '0;
        end else if (s.cnt == `ACS_INSTR_CLKS - 5'h01) begin
          n.st  = ST_CONV;
          n.cnt = '0;
        end else begin
          n.cnt = s.cnt + 5'h01;
        end
      end
      ST_CONV: begin
        if (!s.go) begin
          // Abort: partial code is dropped, result untouched
          n.st  = ST_WAIT;
          n.cnt = '0;
        end else if (tick) begin
          if (s.cnt == 5'h00) begin
            n.trial = `ACS_SAR_MSB;
            n.cnt   = 5'h01;
          end else begin
            tmp[bidx] = cmp_in;
            if (bidx != 4'h0) begin
              tmp[bidx - 4'h1] = 1'b1;
            end
            n.trial = tmp;
            if (s.cnt == `ACS_CONV_TADS - 5'h01) begin
              n.result = tmp;
              n.go     = 1'b0;
              n.done   = 1'b1;
              n.st     = ST_WAIT;
              n.cnt    = '0;
            end else begin
              n.cnt = s.cnt + 5'h01;
            end
          end
        end
      end
      // Settling gap after completion or abort
      ST_WAIT: begin
        if (tick) begin
          if (s.cnt == `ACS_WAIT_TADS - 5'h01) begin
            n.st  = ST_DISCH;
            n.cnt = '0;
          end else begin
            n.cnt = s.cnt + 5'h01;
          end
        end
      end
      default: begin
        n.st  = ST_OFF;
        n.cnt = '0;
      end
    endcase

    // Switching off aborts at once and drops start
    if (!n.on) begin
      n.st = ST_OFF;
      n.go = 1'b0;
    end
    // With the divider, each new phase begins on a fresh bit period; the RC source keeps its own phase
    n.rdiv = (n.st != s.st);

    n.ana.discharge = (n.st == ST_DISCH);
    n.ana.sample    = (n.st == ST_SAMPLE) | (n.st == ST_ACQ) | (n.st == ST_DLY);
    n.ana.convert   = (n.st == ST_CONV);
    n.ana.trial     = n.trial;
    n.ana.channel   = n.chs;
  end

  // State register; reset leaves the converter off and idle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s       <= '0;
      s.wreq  <= 1'b1;
      s.ancfg <= `ACS_ANCFG_RST;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign ana             = s.ana;
  assign timer_clear     = s.tclr;

  // Helper counters for the checks: ticks and clocks in the current phase
  logic [4:0] h_ticks;
  logic [4:0] h_clks;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      h_ticks <= '0;
      h_clks  <= '0;
    end else if (clk_en) begin
      h_ticks <= (n.st != s.st) ? 5'h00 : h_ticks + 5'(tick);
      h_clks  <= (n.st != s.st) ? 5'h00 : h_clks + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_conv_eleven_tads: assert property (
    clk_en && s.st == ST_CONV && n.st == ST_WAIT && s.go |-> tick && h_ticks == 5'h0a)
    else $error("conversion did not last eleven bit periods");
  chk_acq_len_tads: assert property (
    clk_en && s.st == ST_ACQ && n.st == ST_CONV |-> tick && h_ticks == acq_len - 5'h01)
    else $error("acquisition length mismatch");
  chk_dly_instr_cycle: assert property (
    clk_en && s.st == ST_DLY && n.st == ST_CONV |-> h_clks == 5'h03)
    else $error("instruction delay not four clocks");
  chk_abort_keeps_result: assert property (
    clk_en && s.st == ST_CONV && !s.go && !wr_take |=> s.st == ST_WAIT && $stable(s.result))
    else $error("abort changed result or phase");
  chk_wait_two_tads: assert property (
    clk_en && s.st == ST_WAIT && n.st == ST_DISCH |-> tick && h_ticks == 5'h01)
    else $error("post-conversion wait not two periods");
  chk_disch_before_sample: assert property (
    clk_en && n.st == ST_SAMPLE && s.st != ST_SAMPLE |-> s.st == ST_DISCH)
    else $error("sampling entered without discharge");
  chk_done_on_complete: assert property (
    $rose(s.done) |-> !s.go && s.st == ST_WAIT && $past(s.st) == ST_CONV)
    else $error("done flag without completed conversion");
  chk_trig_clears_timer: assert property (
    clk_en && trig_ok |=> timer_clear ##1 (!timer_clear || !clk_en || trig_ok))
    else $error("trigger did not pulse timer clear");
  chk_trig_when_off: assert property (
    clk_en && trig_ok && !s.on && !wr_take |=> !s.go && timer_clear)
    else $error("trigger acted while converter off");
  chk_trig_starts: assert property (
    clk_en && trig_ok && s.on && !wr_take |=> s.go)
    else $error("trigger did not set start");
  chk_port_analog_zero: assert property (
    clk_en && avs_read && s.wreq && avs_address == `ACS_ADDR_PORT
    |=> (s.rdata[`ACS_PORT_W-1:0] & $past(s.ancfg)) == '0)
    else $error("analog pin read as one");
  chk_off_idle: assert property (
    clk_en && !n.on |=> s.st == ST_OFF && !s.go)
    else $error("converter off but sequencer active");

  cov_complete: cover property (clk_en && s.st == ST_CONV && n.st == ST_WAIT && s.go);
  cov_abort:    cover property (clk_en && s.st == ST_CONV && !s.go);
  cov_trigger:  cover property (clk_en && trig_ok && s.on);
  cov_acq_four: cover property (clk_en && s.st == ST_ACQ && n.st == ST_CONV && s.acq == 3'h2);

endmodule

`default_nettype wire

// ### verif/acs_ana_model.sv
/*
  Behavioural comparator array that answers the converter sequencer.
  Assumes ana is registered on core_clk and vin is held during a conversion.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module acs_ana_model
  import acs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire acs_ana_t              ana,
  input  wire logic [`ACS_RES_W-1:0] vin,
  output logic                       cmp_in
);
  logic idle_r = 1'b0; // Idle pattern, so no stale comparator level is ever seen

  // Toggle every cycle; drives cmp_in only while the array is not converting
  always_ff @(posedge core_clk) begin
    idle_r <= ~idle_r;
  end

  // Keep the trial bit while the trial code does not exceed the input level
  assign cmp_in = ana.convert ? (ana.trial <= vin) : idle_r;
endmodule
`default_nettype wire

// ### verif/adc_conversion_sequencer_tb.sv
/*
  Self-checking bench of the converter sequencer over Avalon-MM.
  Assumes the design answers each access after one wait state.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"

module adc_conversion_sequencer_tb
  import acs_pkg::*;
;
  logic        core_clk = 1'b0;     // 25 MHz system clock
  logic        rc_clk_in = 1'b0;    // RC source, 1 us period, free running
  logic        resetn = 1'b0;       // Active low reset
  logic        avs_read = 1'b0;     // Bus read strobe
  logic        avs_write = 1'b0;    // Bus write strobe
  logic [7:0]  avs_address = 8'h00; // Byte address
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        special_trig = 1'b0; // Compare unit event pulse
  logic [7:0]  port_pins = 8'ha5;   // Digital pin levels
  logic        cmp_in;
  logic        timer_clear;
  acs_ana_t    ana;
  logic [9:0]  vin = 10'h000;       // Level seen by the array
  logic [31:0] rd;                  // Last read data
  logic        prev_d = 1'b0;
  logic        prev_s = 1'b0;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n, ta, tc, tw, p;
  logic [9:0]  vtab [8] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h155, 10'h2aa, 10'h001, 10'h3fe};
  int          dv [8] = '{2, 8, 32, 22, 4, 16, 64, 22}; // Divider per select code; 22 marks RC
  int          at [8] = '{0, 2, 4, 6, 8, 12, 16, 20};   // Acquisition periods per code

  always #20 core_clk = ~core_clk;
  always #500 rc_clk_in = ~rc_clk_in;

  acs_sequencer u_dut (
    .core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in),
    .rc_clk_in(rc_clk_in), .special_trig(special_trig), .port_pins(port_pins),
    .ana(ana), .timer_clear(timer_clear)
  );

  acs_ana_model u_ana (.core_clk(core_clk), .ana(ana), .vin(vin), .cmp_in(cmp_in));

  // Verdict and end of run
  task end_sim;
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task rng(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ws;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // Look at the answer mid-cycle, where it has settled, then pass that edge
    ws = 1'b1;
    while (ws !== 1'b0) begin
      @(negedge core_clk);
      ws = avs_waitrequest;
      rd = avs_readdata;
      @(posedge core_clk);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Count edges until an analog control reaches a level, bounded by lim
  task wait_bit(input int w, input logic lvl, input int lim);
    n = 0;
    while ((w == 0 ? ana.discharge : w == 1 ? ana.sample : ana.convert) !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // Full conversion on channel 5, measuring acquisition, conversion and wait
  task run_conv(input logic [2:0] cs, input logic [2:0] acq, input logic [9:0] v);
    bus(1'b1, `ACS_ADDR_TIMING, {26'h0, acq, cs});
    wait_bit(1, 1'b1, 3000);
    vin <= v;
    bus(1'b1, `ACS_ADDR_CTRL, 32'h17);
    wait_bit(2, 1'b1, 3000);
    ta = n;
    wait_bit(2, 1'b0, 3000);
    tc = n;
    wait_bit(0, 1'b1, 3000);
    tw = n;
    bus(1'b0, `ACS_ADDR_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    rdchk(`ACS_ADDR_RESULT, {22'h0, v});
    rdchk(`ACS_ADDR_CTRL, 32'h15);
    bus(1'b1, `ACS_ADDR_STATUS, 32'h1);
  endtask

  // Special event pulse; counts timer clears and watches for a conversion
  task trig(input int ec, input int ev);
    int k;
    k = 0;
    special_trig <= 1'b1;
    @(posedge core_clk);
    special_trig <= 1'b0;
    repeat (6) begin
      @(posedge core_clk);
      if (timer_clear === 1'b1) k++;
    end
    rng(k, ec, ec);
    wait_bit(2, 1'b1, 400);
    rng(n < 400 ? 1 : 0, ev, ev);
    if (ev == 1) wait_bit(2, 1'b0, 3000);
  endtask

  // Every rise of sample must follow a discharge phase
  always @(posedge core_clk) begin
    if (resetn && ana.sample === 1'b1 && !prev_s) begin
      total_checks++;
      if (prev_d !== 1'b1) begin
        err_total++;
        $display("[ERR] %0t sampling without discharge", $time);
      end
    end
    prev_d <= ana.discharge;
    prev_s <= (ana.sample === 1'b1);
  end

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      end_sim;
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk(ana, 32'h0);
    bus(1'b1, 8'h1c, 32'hffffffff);
    rdchk(8'h1c, 32'h0);
    rdchk(`ACS_ADDR_CTRL, 32'h0);
    rdchk(`ACS_ADDR_TIMING, 32'h0);
    rdchk(`ACS_ADDR_ANCFG, 32'hff);
    bus(1'b1, `ACS_ADDR_ANCFG, 32'h0f);
    bus(1'b1, `ACS_ADDR_PORT, 32'hff);
    rdchk(`ACS_ADDR_PORT, 32'ha0);
    bus(1'b1, `ACS_ADDR_CTRL, 32'h15);
    // Every clock select and acquisition code once; codes x11 run on the RC source,
    // and the system clock is never switched while a conversion runs
    for (int i = 0; i < 8; i++) begin
      run_conv(i[2:0], i[2:0], vtab[i]);
      p = tc / 11;
      rng(tc, 11 * dv[i], 11 * (dv[i] + 3) + 6);
      rng(ta, i == 0 ? 3 : at[i] * (p - 1), at[i] * (p + 1) + p + 8);
      rng(tw, i % 4 == 3 ? p - 2 : 2 * p - 2, 2 * p + 8);
    end
    // Abort in mid-conversion keeps the written result
    bus(1'b1, `ACS_ADDR_RESULT, 32'h155);
    bus(1'b1, `ACS_ADDR_TIMING, 32'h38);
    wait_bit(1, 1'b1, 3000);
    vin <= 10'h2aa;
    bus(1'b1, `ACS_ADDR_CTRL, 32'h17);
    wait_bit(2, 1'b1, 3000);
    repeat (5) @(posedge core_clk);
    bus(1'b1, `ACS_ADDR_CTRL, 32'h15);
    @(posedge core_clk);
    chk(ana.convert, 32'h0);
    wait_bit(0, 1'b1, 3000);
    rng(n, 0, 40);
    rdchk(`ACS_ADDR_STATUS, 32'h0);
    rdchk(`ACS_ADDR_RESULT, 32'h155);
    // Special event trigger in mode 0 while on, then in mode 1011 while on and while off
    bus(1'b1, `ACS_ADDR_TIMING, 32'h0);
    wait_bit(1, 1'b1, 3000);
    vin <= 10'h0f0;
    trig(0, 0);
    bus(1'b1, `ACS_ADDR_TRIG, 32'hb);
    trig(1, 1);
    rdchk(`ACS_ADDR_RESULT, 32'h0f0);
    bus(1'b1, `ACS_ADDR_CTRL, 32'h0);
    trig(1, 0);
    // Reset during a conversion
    bus(1'b1, `ACS_ADDR_CTRL, 32'h15);
    bus(1'b1, `ACS_ADDR_TIMING, 32'h38);
    wait_bit(1, 1'b1, 3000);
    bus(1'b1, `ACS_ADDR_CTRL, 32'h17);
    wait_bit(2, 1'b1, 3000);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(ana, 32'h0);
    resetn <= 1'b1;
    @(posedge core_clk);
    rdchk(`ACS_ADDR_CTRL, 32'h0);
    rdchk(`ACS_ADDR_STATUS, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
